//--- rtl/tiacal_pkg.sv
// Constants shared by the TIA result calibration block
package tiacal_pkg;
   // Register byte addresses
   localparam logic [15:0] LOCK_ADDR    = 16'h2230;
   localparam logic [15:0] HS_OFF_ADDR  = 16'h2234;
   localparam logic [15:0] HS_GAIN_ADDR = 16'h2284;
   localparam logic [15:0] LP_OFF_ADDR  = 16'h2288;
   localparam logic [15:0] LP_GAIN_ADDR = 16'h228C;
   // Field layout of the calibration words
   localparam int CAL_W    = 15;
   localparam int CAL_MSB  = 14;
   localparam int FRAC_W   = 14;
   localparam int QUART_W  = 2;
   // Reset values
   localparam logic [14:0] OFF_RST  = 15'h0000;
   localparam logic [14:0] GAIN_RST = 15'h4000;
   localparam logic [31:0] LOCK_RST = 32'h00000000;
   // Unlock key for the calibration words
   localparam logic [31:0] UNLOCK_KEY = 32'hDE87A5AF;
   // Illegal gain code
   localparam logic [14:0] GAIN_ZERO = 15'h0000;
   // Output range limits
   localparam logic [15:0] RES_MAX = 16'hFFFF;
   localparam logic [15:0] RES_MIN = 16'h0000;
   // Bus answers
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   localparam logic [1:0] RESP_DECERR = 2'h3;
endpackage : tiacal_pkg

//--- rtl/tiacal_top.sv
// TIA result calibration: offset, gain and saturation behind AXI4-Lite
// Notes on behaviour
// - Low power results get signed quarter-LSB offset
// - Offset codes are 15-bit two's complement
// - High speed channel has own offset
// - Gain code 0x4000 means unity
// - Gain scales linearly, LSB is 2^-14
// - Gain zero forces result zero
// - High speed channel has own gain
// - Offsets reset to zero
// - Gain bit 14 integer, 13:0 fraction
// - Calibration writes need unlock key first
//
// The AXI4-Lite register port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module tiacal_top (
   // Clock and reset
   input  wire logic        aclk,
   input  wire logic        aresetn,
   // Write address channel
   input  wire logic        awvalid,
   output var  logic        awready,
   input  wire logic [15:0] awaddr,
   // Write data channel
   input  wire logic        wvalid,
   output var  logic        wready,
   input  wire logic [31:0] wdata,
   input  wire logic [3:0]  wstrb,
   // Write response channel
   output var  logic        bvalid,
   input  wire logic        bready,
   output var  logic [1:0]  bresp,
   // Read address channel
   input  wire logic        arvalid,
   output var  logic        arready,
   input  wire logic [15:0] araddr,
   // Read data channel
   output var  logic        rvalid,
   input  wire logic        rready,
   output var  logic [31:0] rdata,
   output var  logic [1:0]  rresp,
   // Raw results from the ADC datapath
   input  wire logic        raw_valid,
   input  wire logic        raw_hs,
   input  wire logic [15:0] raw_code,
   // Corrected results
   output var  logic        result_valid,
   output var  logic        result_hs,
   output var  logic [15:0] conversion_result
);

   // Whole block state
   typedef struct packed {
      logic               awready;   // Address slot free
      logic               wready;    // Data slot free
      logic               aw_full;   // Address held
      logic               w_full;    // Data held
      logic [15:0]        awaddr;    // Held address
      logic [31:0]        wdata;     // Held data
      logic [3:0]         wstrb;     // Held strobes
      logic               bvalid;    // Write answer pending
      logic [1:0]         bresp;     // Write answer code
      logic               arready;   // Read slot free
      logic               rvalid;    // Read answer pending
      logic [31:0]        rdata;     // Read answer data
      logic [1:0]         rresp;     // Read answer code
      logic [31:0]        lock_key;  // Last key written
      logic [14:0]        hs_off;    // High speed offset
      logic [14:0]        hs_gain;   // High speed gain
      logic [14:0]        lp_off;    // Low power offset
      logic [14:0]        lp_gain;   // Low power gain
      logic               p1_valid;  // Stage 1 holds a sample
      logic               p1_hs;     // Stage 1 channel
      logic signed [19:0] p1_sum;    // Quarter-LSB sum
      logic [14:0]        p1_gain;   // Gain for stage 2
      logic               res_valid; // Result strobe
      logic               res_hs;    // Result channel
      logic [15:0]        result;    // Corrected result
   } tiacal_state_type;

   // Reset image of the state
   localparam tiacal_state_type RST_STATE = '{
      awready:  1'b1,
      wready:   1'b1,
      arready:  1'b1,
      lock_key: tiacal_pkg::LOCK_RST,
      hs_off:   tiacal_pkg::OFF_RST,
      lp_off:   tiacal_pkg::OFF_RST,
      hs_gain:  tiacal_pkg::GAIN_RST,
      lp_gain:  tiacal_pkg::GAIN_RST,
      default:  '0
   };

   tiacal_state_type   s;         // Current state
   tiacal_state_type   next_s;    // Next state
   logic [31:0]        wmask;     // Byte lanes as bits
   logic [31:0]        wbits;     // Written bits only
   logic [31:0]        keep;      // Bits left alone
   logic               unlocked;  // Key matches
   logic               wr_go;     // Write performed now
   logic [14:0]        sel_off;   // Offset of sample
   logic [14:0]        sel_gain;  // Gain of sample
   logic signed [35:0] prod;      // Sum times gain
   logic signed [19:0] scaled;    // Back to whole LSBs

   // Strobes to bit mask
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         wmask[8*i +: 8] = {8{s.wstrb[i]}};
      end
   end

   assign wbits    = s.wdata & wmask;
   assign keep     = ~wmask;
   assign unlocked = (s.lock_key == tiacal_pkg::UNLOCK_KEY);
   assign wr_go    = s.aw_full && s.w_full && !s.bvalid;

   // Channel picks its own pair
   assign sel_off  = raw_hs ? s.hs_off : s.lp_off;
   assign sel_gain = raw_hs ? s.hs_gain : s.lp_gain;

   // Gain is unsigned Q1.14; quarter LSBs drop two more bits
   assign prod   = s.p1_sum * $signed({21'h000000, s.p1_gain});
   assign scaled = prod[35 -: 20];

   // Next state
   always_comb begin
      next_s = s;
      // Address and data are caught in either order
      if (awvalid && s.awready) begin
         next_s.aw_full = 1'b1;
         next_s.awaddr  = awaddr;
      end
      if (wvalid && s.wready) begin
         next_s.w_full = 1'b1;
         next_s.wdata  = wdata;
         next_s.wstrb  = wstrb;
      end
      // Answer retired
      if (s.bvalid && bready) begin
         next_s.bvalid = 1'b0;
      end
      // Both halves held and no answer pending: perform the write
      if (wr_go) begin
         next_s.aw_full = 1'b0;
         next_s.w_full  = 1'b0;
         next_s.bvalid  = 1'b1;
         next_s.bresp   = tiacal_pkg::RESP_OKAY;
         unique case (s.awaddr)
            tiacal_pkg::LOCK_ADDR: begin
               next_s.lock_key = (s.lock_key & keep) | wbits;
            end
            tiacal_pkg::HS_OFF_ADDR: begin
               // Locked words refuse the write with an error
               if (unlocked) begin
                  next_s.hs_off = (s.hs_off & keep[14:0]) | wbits[14:0];
               end else begin
                  next_s.bresp = tiacal_pkg::RESP_SLVERR;
               end
            end
            tiacal_pkg::HS_GAIN_ADDR: begin
               if (unlocked) begin
                  next_s.hs_gain = (s.hs_gain & keep[14:0]) | wbits[14:0];
               end else begin
                  next_s.bresp = tiacal_pkg::RESP_SLVERR;
               end
            end
            tiacal_pkg::LP_OFF_ADDR: begin
               if (unlocked) begin
                  next_s.lp_off = (s.lp_off & keep[14:0]) | wbits[14:0];
               end else begin
                  next_s.bresp = tiacal_pkg::RESP_SLVERR;
               end
            end
            tiacal_pkg::LP_GAIN_ADDR: begin
               if (unlocked) begin
                  next_s.lp_gain = (s.lp_gain & keep[14:0]) | wbits[14:0];
               end else begin
                  next_s.bresp = tiacal_pkg::RESP_SLVERR;
               end
            end
            default: begin
               // Nothing decoded here
               next_s.bresp = tiacal_pkg::RESP_DECERR;
            end
         endcase
      end
      next_s.awready = !next_s.aw_full;
      next_s.wready  = !next_s.w_full;

      // Read: answer one cycle after the address is taken
      if (arvalid && s.arready) begin
         next_s.rvalid = 1'b1;
         next_s.rresp  = tiacal_pkg::RESP_OKAY;
         unique case (araddr)
            tiacal_pkg::LOCK_ADDR:    next_s.rdata = s.lock_key;
            tiacal_pkg::HS_OFF_ADDR:  next_s.rdata = {17'h00000, s.hs_off};
            tiacal_pkg::HS_GAIN_ADDR: next_s.rdata = {17'h00000, s.hs_gain};
            tiacal_pkg::LP_OFF_ADDR:  next_s.rdata = {17'h00000, s.lp_off};
            tiacal_pkg::LP_GAIN_ADDR: next_s.rdata = {17'h00000, s.lp_gain};
            default: begin
               next_s.rdata = 32'h00000000;
               next_s.rresp = tiacal_pkg::RESP_DECERR;
            end
         endcase
      end else if (s.rvalid && rready) begin
         next_s.rvalid = 1'b0;
      end
      next_s.arready = !next_s.rvalid;

      // Stage 1: offset added in quarter LSBs; idle cycles keep the last sample
      next_s.p1_valid = raw_valid;
      if (raw_valid) begin
         next_s.p1_hs   = raw_hs;
         next_s.p1_gain = sel_gain;
         next_s.p1_sum  = $signed({2'b00, raw_code, 2'b00})
                        + $signed({{5{sel_off[14]}}, sel_off});
      end

      // Stage 2: gain, then clamp; result holds until the next sample
      next_s.res_valid = s.p1_valid;
      if (s.p1_valid) begin
         next_s.res_hs = s.p1_hs;
         if (s.p1_gain == tiacal_pkg::GAIN_ZERO) begin
            next_s.result = tiacal_pkg::RES_MIN;
         end else if (scaled[19]) begin
            // Negative sums clamp to the bottom of the range
            next_s.result = tiacal_pkg::RES_MIN;
         end else if (|scaled[18:16]) begin
            // Sums beyond full scale clamp to the top
            next_s.result = tiacal_pkg::RES_MAX;
         end else begin
            next_s.result = scaled[15:0];
         end
      end
   end

   // State register; reset gives zero offsets and unity gains
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s <= RST_STATE;
      end else begin
         s <= next_s;
      end
   end

   // Outputs straight from flops
   assign awready           = s.awready;
   assign wready            = s.wready;
   assign bvalid            = s.bvalid;
   assign bresp             = s.bresp;
   assign arready           = s.arready;
   assign rvalid            = s.rvalid;
   assign rdata             = s.rdata;
   assign rresp             = s.rresp;
   assign result_valid      = s.res_valid;
   assign result_hs         = s.res_hs;
   assign conversion_result = s.result;

   // Checks on the calibration behaviour
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   // Unity gain, no offset, low power sample
   sequence lp_plain_in;
      raw_valid && !raw_hs && s.lp_off == tiacal_pkg::OFF_RST
      && s.lp_gain == tiacal_pkg::GAIN_RST;
   endsequence
   sequence passes_through;
      ##2 result_valid && conversion_result == $past(raw_code, 2);
   endsequence

   a_unity_pass: assert property (lp_plain_in |-> passes_through)
      else $error("unity gain changed the result");

   a_zero_gain: assert property (s.p1_valid && s.p1_gain == tiacal_pkg::GAIN_ZERO
      |=> result_valid && conversion_result == tiacal_pkg::RES_MIN)
      else $error("zero gain did not give zero");

   a_hs_pick: assert property (raw_valid && raw_hs
      |=> s.p1_gain == $past(s.hs_gain) && s.p1_hs)
      else $error("high speed sample used wrong gain");

   a_lp_offset: assert property (raw_valid && !raw_hs
      |=> s.p1_sum == $past($signed({2'b00, raw_code, 2'b00})
                    + $signed({{5{s.lp_off[14]}}, s.lp_off})))
      else $error("low power offset sum wrong");

   // High speed samples take only their own offset
   a_hs_offset: assert property (raw_valid && raw_hs
      |=> s.p1_sum == $past($signed({2'b00, raw_code, 2'b00})
                    + $signed({{5{s.hs_off[14]}}, s.hs_off})))
      else $error("high speed offset sum wrong");

   // Reset checks stay live across the release edge itself
   sequence reset_left;
      $rose(aresetn);
   endsequence

   a_offset_reset: assert property (disable iff (1'b0) reset_left
      |-> s.lp_off == tiacal_pkg::OFF_RST && s.hs_off == tiacal_pkg::OFF_RST)
      else $error("offsets not zero after reset");

   a_gain_reset: assert property (disable iff (1'b0) reset_left
      |-> s.lp_gain == tiacal_pkg::GAIN_RST && s.hs_gain == tiacal_pkg::GAIN_RST)
      else $error("gains not unity after reset");

   // A write that meets a locked bank changes nothing and is refused
   sequence locked_cal_write;
      wr_go && !unlocked && s.awaddr != tiacal_pkg::LOCK_ADDR;
   endsequence

   a_lock_guard: assert property (locked_cal_write
      |=> $stable(s.lp_gain) && $stable(s.hs_gain)
          && $stable(s.lp_off) && $stable(s.hs_off))
      else $error("locked calibration word changed");

   a_lock_answer: assert property (locked_cal_write
      |=> bvalid && bresp != tiacal_pkg::RESP_OKAY)
      else $error("locked write was answered okay");

   // The key word itself is always writable, else the bank could never open
   a_key_write: assert property (wr_go && s.awaddr == tiacal_pkg::LOCK_ADDR
      && s.wstrb == 4'hF |=> s.lock_key == $past(s.wdata))
      else $error("lock key not stored");

   a_reserved_zero: assert property (arvalid && arready
      && araddr != tiacal_pkg::LOCK_ADDR |=> rvalid && rdata[31:15] == 17'h00000)
      else $error("reserved bits read nonzero");

   a_sat_high: assert property (s.p1_valid && s.p1_gain != tiacal_pkg::GAIN_ZERO
      && !scaled[19] && scaled[18:16] != 3'h0
      |=> conversion_result == tiacal_pkg::RES_MAX)
      else $error("overflow not clamped high");

   a_sat_low: assert property (s.p1_valid && s.p1_gain != tiacal_pkg::GAIN_ZERO
      && s.p1_sum < 0 |=> conversion_result == tiacal_pkg::RES_MIN)
      else $error("negative sum not clamped low");

   // Between samples the corrected value must not move
   a_result_hold: assert property (!s.p1_valid
      |=> !result_valid && $stable(conversion_result))
      else $error("result moved without a sample");

endmodule : tiacal_top
`default_nettype wire

//--- test/tiacal_adc_src.sv
// Behavioural ADC datapath that feeds raw results into the block
`timescale 1ns/1ps
`default_nettype none
module tiacal_adc_src (
   // Clock
   input  wire logic        aclk,
   // Request from the bench
   input  wire logic        go,
   input  wire logic        go_hs,
   input  wire logic [15:0] go_code,
   // Raw sample stream
   output var  logic        raw_valid,
   output var  logic        raw_hs,
   output var  logic [15:0] raw_code
);
   // One strobe per request; idle fields flip so stale data never passes for a sample
   always_ff @(posedge aclk) begin
      raw_valid <= go;
      raw_hs    <= go ? go_hs : ~raw_hs;
      raw_code  <= go ? go_code : ~raw_code;
   end
endmodule : tiacal_adc_src
`default_nettype wire

//--- test/tia_adc_result_calibration_tb_top.sv
// Self-checking bench for the TIA result calibration block
`timescale 1ns/1ps
`default_nettype none
module tia_adc_result_calibration_tb_top;
   // Bench-driven inputs
   logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, go, go_hs;
   logic [15:0] awaddr, araddr, go_code, c;
   logic [31:0] wdata, rd;
   logic [3:0]  wstrb;
   logic [1:0]  rsp;
   // Design outputs
   wire logic        awready, wready, bvalid, arready, rvalid, raw_valid, raw_hs;
   wire logic        result_valid, result_hs;
   wire logic [1:0]  bresp, rresp;
   wire logic [31:0] rdata;
   wire logic [15:0] raw_code, conversion_result;
   // Bookkeeping
   int          num_errors, total_checks, seed, i, k;
   logic [14:0] off, gn, hoff, hgn;
   // Corner codes for offset and gain
   logic [14:0] otab [5] = '{15'h3FFF, 15'h0001, 15'h0000, 15'h7FFF, 15'h4000};
   logic [14:0] gtab [7] = '{15'h7FFF, 15'h4001, 15'h4000, 15'h3FFF, 15'h2000, 15'h0001,
                             15'h0000};

   tiacal_top u_dut (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
      .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
      .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready),
      .araddr(araddr), .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
      .raw_valid(raw_valid), .raw_hs(raw_hs), .raw_code(raw_code),
      .result_valid(result_valid), .result_hs(result_hs),
      .conversion_result(conversion_result));
   tiacal_adc_src u_src (.aclk(aclk), .go(go), .go_hs(go_hs), .go_code(go_code),
      .raw_valid(raw_valid), .raw_hs(raw_hs), .raw_code(raw_code));

   // Offset in quarter steps, then Q1.14 gain, then clamp to 16 bits
   function automatic logic [15:0] calc(input logic [15:0] r, input logic [14:0] o,
                                        input logic [14:0] g);
      longint s;
      s = longint'(r) * 4 + (o[14] ? longint'(o) - 32768 : longint'(o));
      s = (s * longint'(g)) >>> 16;
      if (g == 15'h0000 || s < 0) return 16'h0000;
      if (s > 65535) return 16'hFFFF;
      return s[15:0];
   endfunction : calc

   // Single comparison point
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : chk

   // Verdict and end of run
   task automatic close_out();
      $display("Checks %0d, errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : close_out

   // Bus wait ran out
   task automatic hang();
      num_errors++;
      $display("MISMATCH at %0t: bus timeout", $time);
      close_out();
   endtask : hang

   // Write one word; each half released when taken
   task automatic wr(input logic [15:0] a, input logic [31:0] d);
      int n;
      @(posedge aclk);
      awvalid <= 1'b1;
      awaddr  <= a;
      wvalid  <= 1'b1;
      wdata   <= d;
      wstrb   <= 4'hF;
      bready  <= 1'b1;
      n = 0;
      do begin
         @(posedge aclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
         n++;
      end while (!bvalid && n < 60);
      if (!bvalid) hang();
      rsp = bresp;
      bready <= 1'b0;
   endtask : wr

   // Read one word
   task automatic rdr(input logic [15:0] a);
      int n;
      @(posedge aclk);
      arvalid <= 1'b1;
      araddr  <= a;
      rready  <= 1'b1;
      n = 0;
      do begin
         @(posedge aclk);
         if (arready) arvalid <= 1'b0;
         n++;
      end while (!rvalid && n < 60);
      if (!rvalid) hang();
      rd  = rdata;
      rsp = rresp;
      rready <= 1'b0;
   endtask : rdr

   // One sample through the source; result lands a fixed two edges after it is taken
   task automatic smp(input logic hs, input logic [15:0] v, input logic [15:0] e);
      @(posedge aclk);
      go      <= 1'b1;
      go_hs   <= hs;
      go_code <= v;
      @(posedge aclk);
      go <= 1'b0;
      repeat (2) @(posedge aclk);
      #1;
      chk(result_valid, 32'h1);
      chk(result_hs, hs);
      chk(conversion_result, e);
   endtask : smp

   // Free-running clock
   initial begin
      aclk = 1'b0;
      forever #2.5 aclk = ~aclk;
   end

   // Main sequence
   initial begin
      seed = 50546;
      num_errors = 0;
      total_checks = 0;
      {aresetn, awvalid, wvalid, bready, arvalid, rready, go, go_hs} = '0;
      {awaddr, araddr, go_code, wdata, wstrb} = '0;
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      rdr(tiacal_pkg::HS_OFF_ADDR);
      chk(rd, 32'h0);
      rdr(tiacal_pkg::LP_OFF_ADDR);
      chk(rd, 32'h0);
      rdr(tiacal_pkg::HS_GAIN_ADDR);
      chk(rd, 32'h4000);
      rdr(tiacal_pkg::LP_GAIN_ADDR);
      chk(rd, 32'h4000);
      smp(1'b0, 16'h1234, 16'h1234);
      // Locked bank refuses writes
      wr(tiacal_pkg::HS_GAIN_ADDR, 32'h2000);
      chk(rsp, tiacal_pkg::RESP_SLVERR);
      rdr(tiacal_pkg::HS_GAIN_ADDR);
      chk(rd, 32'h4000);
      rdr(16'h2300);
      chk(rsp, tiacal_pkg::RESP_DECERR);
      chk(rd, 32'h0);
      wr(tiacal_pkg::LOCK_ADDR, tiacal_pkg::UNLOCK_KEY);
      chk(rsp, tiacal_pkg::RESP_OKAY);
      wr(tiacal_pkg::HS_OFF_ADDR, 32'hFFFFFFFF);
      chk(rsp, tiacal_pkg::RESP_OKAY);
      rdr(tiacal_pkg::HS_OFF_ADDR);
      chk(rd, 32'h7FFF);
      // Every corner code pairing plus random high speed settings
      for (i = 0; i < 35; i++) begin
         off  = otab[i % 5];
         gn   = gtab[i % 7];
         hoff = 15'($random(seed));
         hgn  = 15'($random(seed));
         // Random high speed gain never takes the illegal zero gain
         if (hgn == 15'h0000) hgn = tiacal_pkg::GAIN_RST;
         wr(tiacal_pkg::LP_OFF_ADDR, {17'h0, off});
         wr(tiacal_pkg::LP_GAIN_ADDR, {17'h0, gn});
         wr(tiacal_pkg::HS_OFF_ADDR, {17'h0, hoff});
         wr(tiacal_pkg::HS_GAIN_ADDR, {17'h0, hgn});
         for (k = 0; k < 3; k++) begin
            c = (k == 0) ? 16'hFFFF : (k == 1) ? 16'h0000 : 16'($random(seed));
            smp(1'b0, c, calc(c, off, gn));
            smp(1'b1, c, calc(c, hoff, hgn));
         end
      end
      // Clearing the key locks the bank again
      wr(tiacal_pkg::LOCK_ADDR, 32'h0);
      wr(tiacal_pkg::LP_GAIN_ADDR, 32'h4000);
      chk(rsp, tiacal_pkg::RESP_SLVERR);
      rdr(tiacal_pkg::LP_GAIN_ADDR);
      chk(rd, {17'h0, gn});
      // Reset in mid-run brings every word back to its default
      @(posedge aclk);
      aresetn <= 1'b0;
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      rdr(tiacal_pkg::LP_OFF_ADDR);
      chk(rd, 32'h0);
      rdr(tiacal_pkg::HS_OFF_ADDR);
      chk(rd, 32'h0);
      rdr(tiacal_pkg::LP_GAIN_ADDR);
      chk(rd, 32'h4000);
      rdr(tiacal_pkg::LOCK_ADDR);
      chk(rd, 32'h0);
      smp(1'b1, 16'hABCD, 16'hABCD);
      close_out();
   end
endmodule : tia_adc_result_calibration_tb_top
`default_nettype wire
